/* hw/panel_ctrl.sv */
/*
  Front-panel supervisory logic: control cycle, lamps, sleep timer,
  host settings and property store over an AHB-Lite slave port.
  Assumes inputs synchronous to clk and one AHB-Lite master.
*/
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
// Notes on behaviour
// - Request at zero starts stored default waveform if present, else nothing.
// - Request during waveform halts piston at its present position.
// - Request while idle away from zero starts return to zero.
// - Request during return to zero aborts it, piston stops.
// - Requests honoured only in normal mode, ignored otherwise.
// - Both remote inputs act exactly like the front button.
// - Status lamp steady on while ready to generate.
// - Status lamp blinks fifty per minute in sleep mode.
// - Status lamp blinks fast while waiting for firmware update.
// - Heating lamp off while humidified air simulation disabled.
// - Heating lamp blinks normally while warming up.
// - Heating lamp steady on once warm and usable.
// - Valve fault shows as fast blinking heating lamp.
// - Both end lamps off when piston at neither end.
// - At one end only that end lamp lit steadily.
// - Overrun blinks that end lamp, other lamp steady on.
// - Step error blinks both end lamps together.
// - Return speed stored here, host writes only while connected, default 5 l/s.
// - Sleep mode entered after host configured idle timeout.
// - Step volume, calib steps, type, serial, limits reported to host.
// - Humidified inspiration speed configurable, default 0.5 l/s.
`timescale 1ns/10ps
`include "panel_params.svh"

module panel_ctrl #(
  parameter int SLOW_HALF = `MS_TO_HALF(`SLOW_BLINK_MS),
  parameter int FAST_HALF = `MS_TO_HALF(`FAST_BLINK_MS),
  parameter int SEC_CYC   = `MS_TO_CYC(`SECOND_MS)
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic      [31:0]            hrdata,
  // Operator and remote inputs
  input  wire logic                   button,
  input  wire logic                   remote_opto,
  input  wire logic                   remote_relay,
  // Device condition
  input  wire panel_pkg::piston_pos_t pos,
  input  wire logic                   default_present,
  input  wire logic                   motion_done,
  input  wire logic                   warm_done,
  input  wire logic                   valve_fault,
  input  wire logic                   usb_connected,
  input  wire logic                   fw_update_wait,
  // Outputs
  output panel_pkg::motion_cmd_t      cmd,
  output panel_pkg::leds_t            leds,
  output logic                        sleep_mode,
  output logic      [15:0]            rtz_speed,
  output logic      [15:0]            insp_speed
);

  // ===========================================================
  // Bus slave
  logic        pend_q;
  logic        wr_q;
  logic [31:0] addr_q;
  logic [2:0]  ctrl_q;
  logic [15:0] rtz_q;
  logic [15:0] insp_q;
  logic [15:0] sleep_time_q;
  logic [15:0] idle_sec_q;
  logic        sw_req_q;
  logic        sw_wake_q;
  logic [31:0] prop_rd;
  logic [31:0] rd_mux;
  logic        accept;
  logic        wr_strobe;
  logic        prop_hit;
  panel_pkg::motion_state_t state_q;
  panel_pkg::leds_t         led_q;
  logic        sleep_q;

  assign accept    = hsel && htrans[1] && hready;
  assign wr_strobe = pend_q && wr_q;
  assign prop_hit  = (addr_q >= `OFS_PROP_BASE) && (addr_q <= `OFS_PROP_LAST);

  // Address phase capture; one wait state for every transfer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q    <= 1'b0;
      wr_q      <= 1'b0;
      addr_q    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (accept) begin
      pend_q    <= 1'b1;
      wr_q      <= hwrite;
      addr_q    <= {haddr[31:2], 2'b00};
      hreadyout <= 1'b0;
    end else if (pend_q) begin
      pend_q    <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  // Read data selection; unmapped reads as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_q == `OFS_CTRL) begin
      rd_mux = {29'h0000_0000, ctrl_q};
    end else if (addr_q == `OFS_STATUS) begin
      rd_mux = {20'h0_0000, led_q, 2'b00, valve_fault, warm_done,
                usb_connected, sleep_q, state_q};
    end else if (addr_q == `OFS_RTZ_SPEED) begin
      rd_mux = {16'h0000, rtz_q};
    end else if (addr_q == `OFS_INSP_SPEED) begin
      rd_mux = {16'h0000, insp_q};
    end else if (addr_q == `OFS_SLEEP_TIME) begin
      rd_mux = {16'h0000, sleep_time_q};
    end else if (addr_q == `OFS_IDLE_COUNT) begin
      rd_mux = {16'h0000, idle_sec_q};
    end else if (prop_hit) begin
      rd_mux = prop_rd;
    end
  end

  // Read data register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (pend_q && !wr_q) begin
      hrdata <= rd_mux;
    end
  end

  // Settings registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q       <= `CTRL_RESET;
      rtz_q        <= `RTZ_SPEED_RESET;
      insp_q       <= `INSP_SPEED_RESET;
      sleep_time_q <= `SLEEP_TIME_RESET;
    end else if (wr_strobe) begin
      if (addr_q == `OFS_CTRL) begin
        ctrl_q <= hwdata[2:0];
      end else if (addr_q == `OFS_RTZ_SPEED) begin
        if (usb_connected) begin
          rtz_q <= hwdata[15:0];
        end
      end else if (addr_q == `OFS_INSP_SPEED) begin
        insp_q <= hwdata[15:0];
      end else if (addr_q == `OFS_SLEEP_TIME) begin
        sleep_time_q <= hwdata[15:0];
      end
    end
  end

  // Command register pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_req_q  <= 1'b0;
      sw_wake_q <= 1'b0;
    end else begin
      sw_req_q  <= wr_strobe && (addr_q == `OFS_COMMAND) && hwdata[`CMD_REQ_BIT];
      sw_wake_q <= wr_strobe && (addr_q == `OFS_COMMAND) && hwdata[`CMD_WAKE_BIT];
    end
  end

  // Property store
  prop_mem u_prop (
    .clk       (clk),
    .wr_en     (wr_strobe && prop_hit && ctrl_q[`CTRL_PROP_WR_BIT]),
    .wr_addr   (addr_q[4:2]),
    .wr_data   (hwdata),
    .rd_addr   (haddr[4:2]),
    .rd_data_q (prop_rd)
  );

  assign rtz_speed  = rtz_q;
  assign insp_speed = insp_q;

  // ===========================================================
  // Control cycle
  logic btn_q;
  logic opto_q;
  logic relay_q;
  logic req;

  // Previous input levels for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      btn_q   <= 1'b0;
      opto_q  <= 1'b0;
      relay_q <= 1'b0;
    end else begin
      btn_q   <= button;
      opto_q  <= remote_opto;
      relay_q <= remote_relay;
    end
  end

  assign req = ctrl_q[`CTRL_NORMAL_BIT] &&
               ((button && !btn_q) || (remote_opto && !opto_q) ||
                (remote_relay && !relay_q) || sw_req_q);

  // Motion state machine and command pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= panel_pkg::MOT_IDLE;
      cmd     <= '0;
    end else begin
      cmd <= '0;
      case (state_q)
        panel_pkg::MOT_IDLE: begin
          if (req && pos.at_zero) begin
            if (default_present) begin
              state_q        <= panel_pkg::MOT_PLAY;
              cmd.start_wave <= 1'b1;
            end
          end else if (req) begin
            state_q       <= panel_pkg::MOT_RTZ;
            cmd.start_rtz <= 1'b1;
          end
        end
        panel_pkg::MOT_PLAY: begin
          if (req) begin
            state_q  <= panel_pkg::MOT_IDLE;
            cmd.halt <= 1'b1;
          end else if (motion_done) begin
            state_q <= panel_pkg::MOT_IDLE;
          end
        end
        panel_pkg::MOT_RTZ: begin
          if (req) begin
            state_q  <= panel_pkg::MOT_IDLE;
            cmd.halt <= 1'b1;
          end else if (motion_done) begin
            state_q <= panel_pkg::MOT_IDLE;
          end
        end
        default: state_q <= panel_pkg::MOT_IDLE;
      endcase
    end
  end

  // ===========================================================
  // Sleep timer
  logic [31:0] sec_cnt_q;
  logic        activity;

  assign activity = req || sw_wake_q || (state_q != panel_pkg::MOT_IDLE);

  // Idle seconds counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_cnt_q  <= 32'h0000_0000;
      idle_sec_q <= 16'h0000;
    end else if (activity) begin
      sec_cnt_q  <= 32'h0000_0000;
      idle_sec_q <= 16'h0000;
    end else if (sec_cnt_q == 32'(SEC_CYC - 1)) begin
      sec_cnt_q <= 32'h0000_0000;
      if (idle_sec_q != 16'hffff) begin
        idle_sec_q <= idle_sec_q + 16'h0001;
      end
    end else begin
      sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_q <= 1'b0;
    end else if ((sleep_time_q != 16'h0000) && (idle_sec_q >= sleep_time_q)
                 && !activity) begin
      sleep_q <= 1'b1;
    end else if (activity) begin
      sleep_q <= 1'b0;
    end
  end

  assign sleep_mode = sleep_q;

  // ===========================================================
  // Blink phases
  logic [31:0] slow_cnt_q;
  logic [31:0] fast_cnt_q;
  logic        slow_q;
  logic        fast_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slow_cnt_q <= 32'h0000_0000;
      slow_q     <= 1'b0;
    end else if (slow_cnt_q == 32'(SLOW_HALF - 1)) begin
      slow_cnt_q <= 32'h0000_0000;
      slow_q     <= !slow_q;
    end else begin
      slow_cnt_q <= slow_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_cnt_q <= 32'h0000_0000;
      fast_q     <= 1'b0;
    end else if (fast_cnt_q == 32'(FAST_HALF - 1)) begin
      fast_cnt_q <= 32'h0000_0000;
      fast_q     <= !fast_q;
    end else begin
      fast_cnt_q <= fast_cnt_q + 32'h0000_0001;
    end
  end

  // ===========================================================
  // Lamp drivers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_q <= '0;
    end else begin
      if (fw_update_wait) begin
        led_q.status <= fast_q;
      end else if (sleep_q) begin
        led_q.status <= slow_q;
      end else begin
        led_q.status <= (state_q == panel_pkg::MOT_IDLE);
      end
      // valve error first, off, warming, warm
      if (valve_fault) begin
        led_q.heat <= fast_q;
      end else if (!ctrl_q[`CTRL_HUMID_BIT]) begin
        led_q.heat <= 1'b0;
      end else if (!warm_done) begin
        led_q.heat <= slow_q;
      end else begin
        led_q.heat <= 1'b1;
      end
      // step error first, overrun, end, off
      if (pos.step_err) begin
        led_q.end_lo <= slow_q;
        led_q.end_hi <= slow_q;
      end else if (pos.over_lo) begin
        led_q.end_lo <= slow_q;
        led_q.end_hi <= 1'b1;
      end else if (pos.over_hi) begin
        led_q.end_lo <= 1'b1;
        led_q.end_hi <= slow_q;
      end else begin
        led_q.end_lo <= pos.end_lo;
        led_q.end_hi <= pos.end_hi && !pos.end_lo;
      end
    end
  end

  assign leds = led_q;

  // ===========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  start_wave_a: assert property (req && state_q == panel_pkg::MOT_IDLE && pos.at_zero
    && default_present |=> cmd.start_wave && state_q == panel_pkg::MOT_PLAY)
    else $error("default waveform not started");
  no_default_a: assert property (req && state_q == panel_pkg::MOT_IDLE && pos.at_zero
    && !default_present |=> cmd == '0 && state_q == panel_pkg::MOT_IDLE)
    else $error("request acted on without default waveform");
  play_halt_a: assert property (req && state_q == panel_pkg::MOT_PLAY
    |=> cmd.halt && !cmd.start_rtz && state_q == panel_pkg::MOT_IDLE)
    else $error("generation not halted");
  rtz_start_a: assert property (req && state_q == panel_pkg::MOT_IDLE && !pos.at_zero
    |=> cmd.start_rtz && state_q == panel_pkg::MOT_RTZ)
    else $error("return to zero not started");
  rtz_abort_a: assert property (req && state_q == panel_pkg::MOT_RTZ
    |=> cmd.halt && state_q == panel_pkg::MOT_IDLE)
    else $error("return to zero not aborted");
  mode_gate_a: assert property (!ctrl_q[`CTRL_NORMAL_BIT]
    |=> cmd == '0)
    else $error("request honoured outside normal mode");
  remote_eq_a: assert property (remote_relay && !relay_q && ctrl_q[`CTRL_NORMAL_BIT]
    && state_q == panel_pkg::MOT_PLAY |=> cmd.halt)
    else $error("relay input ignored");
  heat_off_a: assert property (!valve_fault && !ctrl_q[`CTRL_HUMID_BIT]
    |=> !leds.heat)
    else $error("heating lamp lit while disabled");
  heat_warm_a: assert property (!valve_fault && ctrl_q[`CTRL_HUMID_BIT] && warm_done
    |=> leds.heat)
    else $error("heating lamp not steady when warm");
  step_blink_a: assert property (pos.step_err
    |=> leds.end_lo == $past(slow_q) && leds.end_hi == $past(slow_q))
    else $error("step error lamps wrong");
  end_off_a: assert property (!pos.step_err && !pos.over_lo && !pos.over_hi
    && !pos.end_lo && !pos.end_hi |=> !leds.end_lo && !leds.end_hi)
    else $error("end lamps lit away from ends");
  rtz_lock_a: assert property (wr_strobe && addr_q == `OFS_RTZ_SPEED
    && !usb_connected |=> $stable(rtz_q))
    else $error("return speed written while disconnected");

  play_c: cover property (cmd.start_wave ##[1:20] cmd.halt);
  rtz_c:  cover property (cmd.start_rtz ##[1:60] motion_done);
  read_c: cover property (pend_q && !wr_q && prop_hit);

endmodule : panel_ctrl

/* hw/panel_params.svh */
/*
  Constants for the front-panel supervisory block: register offsets,
  field positions, reset values and timing figures.
  Assumes a 40 MHz system clock and a 32-bit AHB-Lite register bus.
*/
`ifndef PANEL_PARAMS_SVH
`define PANEL_PARAMS_SVH

// ===========================================================
// Register offsets (byte addresses)
`define OFS_CTRL        32'h0000_0000
`define OFS_STATUS      32'h0000_0004
`define OFS_RTZ_SPEED   32'h0000_0008
`define OFS_INSP_SPEED  32'h0000_000c
`define OFS_SLEEP_TIME  32'h0000_0010
`define OFS_COMMAND     32'h0000_0014
`define OFS_IDLE_COUNT  32'h0000_0018
`define OFS_PROP_BASE   32'h0000_0020
`define OFS_PROP_LAST   32'h0000_003c

// ===========================================================
// Field positions
`define CTRL_NORMAL_BIT   0
`define CTRL_HUMID_BIT    1
`define CTRL_PROP_WR_BIT  2
`define CMD_REQ_BIT       0
`define CMD_WAKE_BIT      1

// ===========================================================
// Reset values (speeds in units of 0.1 l/s)
`define CTRL_RESET        3'h1
`define RTZ_SPEED_RESET   16'h0032
`define INSP_SPEED_RESET  16'h0005
`define SLEEP_TIME_RESET  16'h0000

// ===========================================================
// Timing
`define CLK_PERIOD_NS     25
`define SLOW_BLINK_MS     1200
`define FAST_BLINK_MS     200
`define SECOND_MS         1000
`define MS_TO_HALF(ms)    ((ms) * 1000000 / `CLK_PERIOD_NS / 2)
`define MS_TO_CYC(ms)     ((ms) * 1000000 / `CLK_PERIOD_NS)

`endif

/* hw/panel_pkg.sv */
/*
  Types shared by the front-panel supervisory block.
  Assumes panel_params.svh is compiled alongside.
*/
package panel_pkg;

  // Piston motion state
  typedef enum logic [1:0] {
    MOT_IDLE,
    MOT_PLAY,
    MOT_RTZ
  } motion_state_t;

  // Piston position and fault flags from the motor drive
  typedef struct packed {
    logic at_zero;
    logic end_lo;
    logic end_hi;
    logic over_lo;
    logic over_hi;
    logic step_err;
  } piston_pos_t;

  // Front-panel lamps
  typedef struct packed {
    logic status;
    logic heat;
    logic end_lo;
    logic end_hi;
  } leds_t;

  // Motion commands to the motor drive
  typedef struct packed {
    logic start_wave;
    logic halt;
    logic start_rtz;
  } motion_cmd_t;

endpackage : panel_pkg

/* hw/prop_mem.sv */
/*
  Eight-word store for device properties reported to the host.
  Assumes one synchronous write port and a registered read port.
*/
`timescale 1ns/10ps

module prop_mem (
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  input  wire logic [2:0]  rd_addr,
  output logic      [31:0] rd_data_q
);

  logic [31:0] mem_q [8];

  // Write port and registered read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data_q <= mem_q[rd_addr];
  end

endmodule : prop_mem

/* test/panel_ctrl_tb.sv */
/*
  Self-checking bench for panel_ctrl: control cycle, lamps, sleep, settings.
  Assumes small blink and second counts (8, 2, 16) and the piston_model drive.
*/
`timescale 1ns/10ps

module panel_ctrl_tb;
  // ===========================================================
  // Signals
  logic                   clk, rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0]            haddr, hwdata, hrdata, rd;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic [2:0]             rem;
  logic [4:0]             pbits;
  logic                   at_zero, motion_done, dflt, warm, valve, usb, fw;
  logic                   sleep_mode;
  logic [15:0]            rtz_speed, insp_speed;
  panel_pkg::motion_cmd_t cmd;
  panel_pkg::leds_t       leds;
  int                     miscompares, n_checks, cycles;

  panel_ctrl #(.SLOW_HALF(8), .FAST_HALF(2), .SEC_CYC(16)) i_dut (
    .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .button(rem[2]), .remote_opto(rem[1]), .remote_relay(rem[0]),
    .pos({at_zero, pbits}), .default_present(dflt), .motion_done,
    .warm_done(warm), .valve_fault(valve), .usb_connected(usb),
    .fw_update_wait(fw), .cmd, .leds, .sleep_mode, .rtz_speed, .insp_speed
  );

  piston_model i_piston (.clk, .rst, .cmd, .at_zero, .motion_done);

  // Clock source
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // ===========================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One single AHB transfer, held until hready is sampled high
  // Select stays high between calls; only the hang guard ends a wait
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Raise one control input, collect command pulses, compare
  task automatic req(input int i, input logic [2:0] e);
    logic [2:0] s;
    s = 3'h0;
    rem[i] <= 1'b1;
    repeat (4) begin @(posedge clk); s = s | cmd; end
    rem[i] <= 1'b0;
    repeat (3) @(posedge clk);
    chk("cmd", {29'h0, e}, {29'h0, s});
  endtask : req

  // Measure one blink half period of lamp i
  task automatic half(input int i, input int e);
    logic v;
    int   n;
    n = 0;
    repeat (2) @(posedge clk);
    v = leds[i];
    while (leds[i] === v && n < 100) begin @(posedge clk); n++; end
    v = leds[i];
    n = 0;
    while (leds[i] === v && n < 100) begin @(posedge clk); n++; end
    chk("blink half", e, n);
  endtask : half

  // Lamp i holds level v
  task automatic st(input int i, input logic v);
    repeat (2) @(posedge clk);
    repeat (20) begin @(posedge clk); chk("lamp level", {31'h0, v}, {31'h0, leds[i]}); end
  endtask : st

  // ===========================================================
  // Scenarios
  task automatic t_cycle();
    int t;
    req(2, 3'b100);
    ahb(1'b0, 32'h4, 0);
    chk("state play", 1, rd[1:0]);
    req(1, 3'b010);
    req(0, 3'b001);
    req(2, 3'b010);
    req(2, 3'b001);
    t = 0;
    while (at_zero !== 1'b1 && t < 200) begin @(posedge clk); t++; end
    repeat (3) @(posedge clk);
    ahb(1'b0, 32'h4, 0);
    chk("state idle", 0, rd[1:0]);
    dflt <= 1'b0;
    req(2, 3'b000);
    dflt <= 1'b1;
    ahb(1'b1, 32'h0, 32'h0);
    req(2, 3'b000);
    req(0, 3'b000);
    ahb(1'b1, 32'h0, 32'h1);
    ahb(1'b1, 32'h14, 32'h1);
    ahb(1'b0, 32'h4, 0);
    chk("cmd reg start", 1, rd[1:0]);
    ahb(1'b1, 32'h14, 32'h1);
    ahb(1'b0, 32'h4, 0);
    chk("cmd reg halt", 0, rd[1:0]);
    $display("control cycle test done");
  endtask : t_cycle

  task automatic t_settings();
    chk("rtz reset", 32'h32, rtz_speed);
    chk("insp reset", 32'h5, insp_speed);
    ahb(1'b1, 32'h8, 32'h14);
    chk("rtz offline", 32'h32, rtz_speed);
    usb <= 1'b1;
    ahb(1'b1, 32'h8, 32'h14);
    chk("rtz online", 32'h14, rtz_speed);
    ahb(1'b0, 32'h4, 0);
    chk("usb flag", 1, rd[3]);
    ahb(1'b1, 32'hc, 32'ha);
    chk("insp set", 32'ha, insp_speed);
    ahb(1'b1, 32'h0, 32'h5);
    ahb(1'b1, 32'h28, 32'h0000_0159);
    ahb(1'b1, 32'h0, 32'h1);
    ahb(1'b1, 32'h28, 32'h0000_0077);
    ahb(1'b0, 32'h28, 0);
    chk("property", 32'h0000_0159, rd);
    ahb(1'b0, 32'h40, 0);
    chk("unmapped", 32'h0, rd);
    chk("hresp okay", 32'h0, {31'h0, hresp});
    $display("settings test done");
  endtask : t_settings

  task automatic t_end();
    st(1, 1'b0);
    st(0, 1'b0);
    pbits <= 5'b10000;
    st(1, 1'b1);
    st(0, 1'b0);
    pbits <= 5'b01000;
    st(0, 1'b1);
    st(1, 1'b0);
    pbits <= 5'b00100;
    half(1, 8);
    st(0, 1'b1);
    pbits <= 5'b00010;
    half(0, 8);
    st(1, 1'b1);
    pbits <= 5'b00101;
    half(1, 8);
    half(0, 8);
    repeat (12) begin @(posedge clk); chk("ends paired", leds[1], leds[0]); end
    pbits <= 5'b00000;
    $display("end lamp test done");
  endtask : t_end

  task automatic t_heat();
    st(2, 1'b0);
    ahb(1'b1, 32'h0, 32'h3);
    half(2, 8);
    warm <= 1'b1;
    st(2, 1'b1);
    valve <= 1'b1;
    half(2, 2);
    valve <= 1'b0;
    ahb(1'b1, 32'h0, 32'h1);
    st(2, 1'b0);
    $display("heating lamp test done");
  endtask : t_heat

  task automatic t_status();
    int t;
    st(3, 1'b1);
    fw <= 1'b1;
    half(3, 2);
    fw <= 1'b0;
    ahb(1'b1, 32'h14, 32'h2);
    ahb(1'b1, 32'h10, 32'h1);
    chk("sleep early", 0, sleep_mode);
    t = 0;
    while (sleep_mode !== 1'b1 && t < 200) begin @(posedge clk); t++; end
    chk("sleep", 1, sleep_mode);
    half(3, 8);
    ahb(1'b1, 32'h10, 32'h0);
    ahb(1'b1, 32'h14, 32'h2);
    repeat (3) @(posedge clk);
    chk("woken", 0, sleep_mode);
    $display("status lamp test done");
  endtask : t_status

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // ===========================================================
  // Main sequence
  initial begin
    {rst, hsel, hwrite, htrans, haddr, hwdata, hsize} = {1'b1, 71'h0};
    {rem, pbits, warm, valve, usb, fw, dflt} = {12'h0, 1'b1};
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    hsize <= 3'h2;
    @(posedge clk);
    t_settings();
    t_cycle();
    t_end();
    t_heat();
    t_status();
    close_out();
  end
endmodule : panel_ctrl_tb

/* test/piston_model.sv */
/*
  Behavioural motor drive that follows the motion command pulses.
  Assumes one-cycle command pulses on clk and an active-high reset.
*/
`timescale 1ns/10ps

module piston_model #(
  parameter int RTZ_LEN = 40
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire panel_pkg::motion_cmd_t cmd,
  output logic                        at_zero,
  output logic                        motion_done
);
  // ===========================================================
  // Piston motion
  logic homing_q;
  int   left_q;

  // Leaves zero on start, stops on halt, homes after RTZ_LEN cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      at_zero     <= 1'b1;
      motion_done <= 1'b0;
      homing_q    <= 1'b0;
      left_q      <= 0;
    end else begin
      motion_done <= 1'b0;
      if (cmd.start_wave) begin
        at_zero  <= 1'b0;
        homing_q <= 1'b0;
      end else if (cmd.halt) begin
        homing_q <= 1'b0;
      end else if (cmd.start_rtz) begin
        homing_q <= 1'b1;
        left_q   <= RTZ_LEN;
      end else if (homing_q) begin
        left_q <= left_q - 1;
        if (left_q == 1) begin
          homing_q    <= 1'b0;
          at_zero     <= 1'b1;
          motion_done <= 1'b1;
        end
      end
    end
  end
endmodule : piston_model
